// file: design/port_e_bidirectional_io.sv
// Purpose: eight-pin bidirectional port with latch, direction and pin read
// Assumes: pins and peripheral signals are synchronous to clk
// Notes: shares pins with capture/compare, external bus and slave port;
//        a write to the pin-read offset lands in the output latch;
//        unmapped offsets read as zero and ignore writes
// Contract
// - Eight pins each have a bit in the pin-read, output latch and direction registers.
// - A direction bit of 1 makes the pin an input, 0 drives the latch value.
// - Each pin's direction is set on its own, tied to no other pin.
// - Reading the output latch returns the latched value, not the pin level.
// - After reset every pin is a digital input.
// - In microcontroller mode a cleared pin-select bit moves the second channel to the top pin.
// - On the top pin the channel drives compare output when direction is 0 and captures when 1.
// - On 80-pin parts the port works only while the external bus disable bit is set.
// - With the external bus on, the pins carry bus bits 15 to 8 and direction is overridden.
// - External bus use takes priority over every other pin function.
// - With the slave port enabled, pins 0, 1 and 2 become its read, write and select inputs.
`timescale 1ns/1ps
`default_nettype none
module port_e_bidirectional_io #(
    parameter int WIDTH = 8,
    parameter bit IS_80_PIN = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,

    // register port
    input wire logic [port_e_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,

    // port pins
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinOut,
    output logic [WIDTH-1:0] pinOe,

    // second capture/compare channel
    input wire logic compareOut,
    output logic captureIn,

    // external memory bus, high byte
    input wire logic [WIDTH-1:0] busHighByteOut,
    input wire logic busHighByteDrive,
    output logic [WIDTH-1:0] busHighByteIn,
    output logic busActive,

    // parallel slave port controls, active low
    output logic slaveReadN,
    output logic slaveWriteN,
    output logic slaveSelectN
);

    // ****************************************
    // register state
    // ****************************************
    logic [7:0] outputLatch_reg;
    logic [7:0] outputLatch_next;
    logic [7:0] pinDirection_reg;
    logic [7:0] pinDirection_next;
    logic [7:0] memoryControl_reg;
    logic [7:0] memoryControl_next;
    logic [7:0] slavePortControl_reg;
    logic [7:0] slavePortControl_next;
    logic [7:0] deviceConfig_reg;
    logic [7:0] deviceConfig_next;
    logic [7:0] readData_next;

    // ****************************************
    // address decode
    // ****************************************
    wire selPinLevels;
    wire selOutputLatch;
    wire selPinDirection;
    wire selMemoryControl;
    wire selSlavePortControl;
    wire selDeviceConfig;

    // one select per mapped register
    assign selPinLevels = (regAddr == port_e_pkg::OFF_PIN_LEVELS);
    assign selOutputLatch = (regAddr == port_e_pkg::OFF_OUTPUT_LATCH);
    assign selPinDirection = (regAddr == port_e_pkg::OFF_PIN_DIRECTION);
    assign selMemoryControl = (regAddr == port_e_pkg::OFF_MEMORY_CONTROL);
    assign selSlavePortControl = (regAddr == port_e_pkg::OFF_SLAVE_PORT_CONTROL);
    assign selDeviceConfig = (regAddr == port_e_pkg::OFF_DEVICE_CONFIG);

    // ****************************************
    // write strobes
    // ****************************************
    wire wrLatch;
    wire wrDirection;
    wire wrMemoryControl;
    wire wrSlavePortControl;
    wire wrDeviceConfig;

    // a write to the pin-read register lands in the output latch
    assign wrLatch = regWrite & (selPinLevels | selOutputLatch);
    assign wrDirection = regWrite & selPinDirection;
    assign wrMemoryControl = regWrite & selMemoryControl;
    assign wrSlavePortControl = regWrite & selSlavePortControl;
    assign wrDeviceConfig = regWrite & selDeviceConfig;

    // ****************************************
    // next register values
    // ****************************************
    // whole-byte writes, so each direction bit is independent
    assign outputLatch_next = wrLatch ? regWrData : outputLatch_reg;
    assign pinDirection_next = wrDirection ? regWrData : pinDirection_reg;
    assign memoryControl_next = wrMemoryControl ? regWrData : memoryControl_reg;
    assign slavePortControl_next = wrSlavePortControl ? regWrData : slavePortControl_reg;
    assign deviceConfig_next = wrDeviceConfig ? regWrData : deviceConfig_reg;

    // ****************************************
    // read mux
    // ****************************************
    wire [7:0] pinLevels;

    // pin level is sampled regardless of who drives the pin
    assign pinLevels = pinIn;

    wire [7:0] rdPinLevels;
    wire [7:0] rdOutputLatch;
    wire [7:0] rdPinDirection;
    wire [7:0] rdMemoryControl;
    wire [7:0] rdSlavePortControl;
    wire [7:0] rdDeviceConfig;
    wire selMapped;

    // each term is zero unless its register is addressed
    assign rdPinLevels = {8{selPinLevels}} & pinLevels;
    assign rdOutputLatch = {8{selOutputLatch}} & outputLatch_reg;
    assign rdPinDirection = {8{selPinDirection}} & pinDirection_reg;
    assign rdMemoryControl = {8{selMemoryControl}} & memoryControl_reg;
    assign rdSlavePortControl = {8{selSlavePortControl}} & slavePortControl_reg;
    assign rdDeviceConfig = {8{selDeviceConfig}} & deviceConfig_reg;

    // unmapped offsets read back the fixed idle value
    assign selMapped = selPinLevels | selOutputLatch | selPinDirection
        | selMemoryControl | selSlavePortControl | selDeviceConfig;

    // latch reads return the latch, never the pins
    assign readData_next = selMapped
        ? (rdPinLevels | rdOutputLatch | rdPinDirection
            | rdMemoryControl | rdSlavePortControl | rdDeviceConfig)
        : port_e_pkg::READ_UNMAPPED;

    // ****************************************
    // register file flip-flops
    // ****************************************
    // output latch clears at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            outputLatch_reg <= port_e_pkg::RST_OUTPUT_LATCH;
        end else begin
            outputLatch_reg <= outputLatch_next;
        end
    end

    // direction resets to all ones: every pin an input
    always_ff @(posedge clk) begin
        if (rst) begin
            pinDirection_reg <= port_e_pkg::RST_PIN_DIRECTION;
        end else begin
            pinDirection_reg <= pinDirection_next;
        end
    end

    // memory control resets with the external bus disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            memoryControl_reg <= port_e_pkg::RST_MEMORY_CONTROL;
        end else begin
            memoryControl_reg <= memoryControl_next;
        end
    end

    // slave port control resets with the slave port off
    always_ff @(posedge clk) begin
        if (rst) begin
            slavePortControl_reg <= port_e_pkg::RST_SLAVE_PORT_CONTROL;
        end else begin
            slavePortControl_reg <= slavePortControl_next;
        end
    end

    // device configuration resets to the default channel pin
    always_ff @(posedge clk) begin
        if (rst) begin
            deviceConfig_reg <= port_e_pkg::RST_DEVICE_CONFIG;
        end else begin
            deviceConfig_reg <= deviceConfig_next;
        end
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= port_e_pkg::READ_UNMAPPED;
        end else if (regRead) begin
            regRdData <= readData_next;
        end else begin
            regRdData <= port_e_pkg::READ_UNMAPPED;
        end
    end

    // ****************************************
    // function selection
    // ****************************************
    wire extBusDisable;
    wire extBusOn;
    wire slavePortOn;
    wire microMode;
    wire captureRouted;
    wire topIsInput;

    // bus exists only on the larger part and only while not disabled
    assign extBusDisable = memoryControl_reg[port_e_pkg::EXT_BUS_DISABLE_BIT];
    assign extBusOn = IS_80_PIN & ~extBusDisable;

    assign slavePortOn = slavePortControl_reg[port_e_pkg::SLAVE_PORT_ENABLE_BIT];
    assign microMode = deviceConfig_reg[port_e_pkg::MICRO_MODE_BIT];

    // cleared select bit in microcontroller mode moves the channel here
    assign captureRouted = microMode
        & ~deviceConfig_reg[port_e_pkg::CAPTURE_PIN_SELECT_BIT];

    assign topIsInput = pinDirection_reg[port_e_pkg::TOP_PIN];

    // ****************************************
    // per-pin alternate selects
    // ****************************************
    wire [WIDTH-1:0] altSel;
    wire [WIDTH-1:0] altData;
    wire [WIDTH-1:0] slaveSel;

    // only the top pin has a peripheral output; pins 0..2 feed the slave port
    for (genvar p = 0; p < WIDTH; p++) begin : g_select
        wire isTop;
        wire isSlave;

        // fixed pin roles, resolved at elaboration
        assign isTop = (p == port_e_pkg::TOP_PIN);
        assign isSlave = (p == port_e_pkg::SLAVE_READ_PIN)
            | (p == port_e_pkg::SLAVE_WRITE_PIN)
            | (p == port_e_pkg::SLAVE_SELECT_PIN);

        // live selects for this pin
        assign altSel[p] = isTop & captureRouted;
        assign altData[p] = isTop & compareOut;
        assign slaveSel[p] = isSlave & slavePortOn;
    end

    // ****************************************
    // pin cells
    // ****************************************
    // one cell per pin; bus overrides the direction bits inside each
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        port_pin_cell u_cell (
            .clk(clk),
            .rst(rst),
            .latchBit(outputLatch_reg[i]),
            .dirBit(pinDirection_reg[i]),
            .busActive(extBusOn),
            .busDrive(busHighByteDrive),
            .busBit(busHighByteOut[i]),
            .altActive(altSel[i]),
            .altBit(altData[i]),
            .slaveInput(slaveSel[i]),
            .pinOut(pinOut[i]),
            .pinOe(pinOe[i])
        );
    end

    // ****************************************
    // inputs toward peripherals
    // ****************************************
    logic captureIn_next;
    logic [WIDTH-1:0] busIn_next;
    logic slaveRead_next;
    logic slaveWrite_next;
    logic slaveSelect_next;

    // capture sees the top pin only when routed, input, and bus is off
    assign captureIn_next = captureRouted & topIsInput & ~extBusOn
        & pinIn[port_e_pkg::TOP_PIN];

    // bus reads the high byte only while it owns the pins
    assign busIn_next = extBusOn ? pinIn : '0;

    // slave controls idle high unless enabled and the bus is off;
    // the pin cells make these pins inputs whatever their direction bits
    assign slaveRead_next = (slavePortOn & ~extBusOn)
        ? pinIn[port_e_pkg::SLAVE_READ_PIN] : 1'b1;
    assign slaveWrite_next = (slavePortOn & ~extBusOn)
        ? pinIn[port_e_pkg::SLAVE_WRITE_PIN] : 1'b1;
    assign slaveSelect_next = (slavePortOn & ~extBusOn)
        ? pinIn[port_e_pkg::SLAVE_SELECT_PIN] : 1'b1;

    // capture input, low unless the top pin is routed in
    always_ff @(posedge clk) begin
        if (rst) begin
            captureIn <= 1'b0;
        end else begin
            captureIn <= captureIn_next;
        end
    end

    // pin levels toward the bus, zero while the bus is off
    always_ff @(posedge clk) begin
        if (rst) begin
            busHighByteIn <= '0;
        end else begin
            busHighByteIn <= busIn_next;
        end
    end

    // bus ownership, one cycle after the control bit changes
    always_ff @(posedge clk) begin
        if (rst) begin
            busActive <= 1'b0;
        end else begin
            busActive <= extBusOn;
        end
    end

    // slave port controls, idle high
    always_ff @(posedge clk) begin
        if (rst) begin
            slaveReadN <= 1'b1;
            slaveWriteN <= 1'b1;
            slaveSelectN <= 1'b1;
        end else begin
            slaveReadN <= slaveRead_next;
            slaveWriteN <= slaveWrite_next;
            slaveSelectN <= slaveSelect_next;
        end
    end

endmodule
`default_nettype wire

// file: inc/port_e_pkg.sv
// Purpose: shared constants for the eight-pin bidirectional port
// Assumes: plain register port with one-cycle read latency
// Notes: offsets are word indices on the register port
package port_e_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_PIN_LEVELS = 3'h0;
    localparam logic [2:0] OFF_OUTPUT_LATCH = 3'h1;
    localparam logic [2:0] OFF_PIN_DIRECTION = 3'h2;
    localparam logic [2:0] OFF_MEMORY_CONTROL = 3'h3;
    localparam logic [2:0] OFF_SLAVE_PORT_CONTROL = 3'h4;
    localparam logic [2:0] OFF_DEVICE_CONFIG = 3'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int EXT_BUS_DISABLE_BIT = 7;
    localparam int SLAVE_PORT_ENABLE_BIT = 4;
    localparam int CAPTURE_PIN_SELECT_BIT = 0;
    localparam int MICRO_MODE_BIT = 1;
    localparam int TOP_PIN = 7;
    localparam int SLAVE_READ_PIN = 0;
    localparam int SLAVE_WRITE_PIN = 1;
    localparam int SLAVE_SELECT_PIN = 2;

    // ****************************************
    // values after reset
    // ****************************************
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'hff;
    localparam logic [7:0] RST_MEMORY_CONTROL = 8'h80;
    localparam logic [7:0] RST_SLAVE_PORT_CONTROL = 8'h00;
    localparam logic [7:0] RST_DEVICE_CONFIG = 8'h03;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// file: design/port_pin_cell.sv
// Purpose: one port pin, selecting who drives it and whether it drives
// Assumes: function selects are mutually ordered by priority here
// Notes: driver output and enable leave from flip-flops
`timescale 1ns/1ps
`default_nettype none
module port_pin_cell (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // port function
    input wire logic latchBit,
    input wire logic dirBit,
    // external bus function
    input wire logic busActive,
    input wire logic busDrive,
    input wire logic busBit,
    // alternate peripheral output
    input wire logic altActive,
    input wire logic altBit,
    // slave port control input
    input wire logic slaveInput,
    // pin driver
    output logic pinOut,
    output logic pinOe
);

    logic outNext;
    logic oeNext;

    // priority: external bus, then peripheral, then slave port, then port
    always_comb begin
        outNext = latchBit;
        oeNext = ~dirBit;
        if (busActive) begin
            outNext = busBit;
            oeNext = busDrive;
        end else if (altActive) begin
            outNext = altBit;
            oeNext = ~dirBit;
        end else if (slaveInput) begin
            outNext = 1'b0;
            oeNext = 1'b0;
        end
    end

    // registered driver
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
        end else begin
            pinOut <= outNext;
            pinOe <= oeNext;
        end
    end

endmodule
`default_nettype wire

// file: sim/port_e_properties.sv
// Purpose: port pin and register port properties
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the port block after the module
`timescale 1ns/1ps
`default_nettype none
module port_e_properties #(
    parameter int WIDTH = 8,
    parameter bit IS_80_PIN = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [port_e_pkg::ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // pins
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] pinOut,
    input wire logic [WIDTH-1:0] pinOe,
    // peripherals
    input wire logic compareOut,
    input wire logic captureIn,
    input wire logic [WIDTH-1:0] busHighByteOut,
    input wire logic busHighByteDrive,
    input wire logic [WIDTH-1:0] busHighByteIn,
    input wire logic busActive,
    input wire logic slaveReadN,
    input wire logic slaveWriteN,
    input wire logic slaveSelectN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****
    // assertions
    // ****
    // bus has owned the pins for two edges
    sequence busHeld;
        busActive && $past(busActive);
    endsequence
    AST_RESET_INPUTS: assert property ($past(rst) |-> pinOe == '0)
        else $error("pins driven right after reset");
    AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdData == 8'h00)
        else $error("read data not idle");
    AST_PIN_READ: assert property (regRead && regAddr == port_e_pkg::OFF_PIN_LEVELS |=> regRdData == $past(pinIn))
        else $error("pin read differs from pin level");
    AST_BUS_OE: assert property (busHeld |-> pinOe == {WIDTH{$past(busHighByteDrive)}})
        else $error("bus drive enable not on pins");
    AST_BUS_OUT: assert property (busHeld |-> pinOut == $past(busHighByteOut))
        else $error("bus byte not on pins");
    AST_BUS_IN: assert property (busHeld |-> busHighByteIn == $past(pinIn))
        else $error("pin levels not passed to bus");
    AST_BUS_OFF_IN: assert property (!busActive && !$past(busActive) |-> busHighByteIn == '0)
        else $error("bus input live while bus off");
    AST_BUS_SLAVE: assert property (busHeld |-> slaveReadN && slaveWriteN && slaveSelectN)
        else $error("slave controls active under bus");
    AST_BUS_CAPTURE: assert property (busHeld |-> !captureIn)
        else $error("capture active under bus");
    // main scenarios
    cover property (busHeld);
    cover property (regRead && regAddr == port_e_pkg::OFF_PIN_LEVELS);
    cover property (!slaveSelectN);
endmodule
bind port_e_bidirectional_io port_e_properties #(.WIDTH(WIDTH), .IS_80_PIN(IS_80_PIN)) props_i (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .compareOut(compareOut), .captureIn(captureIn), .busHighByteOut(busHighByteOut),
    .busHighByteDrive(busHighByteDrive), .busHighByteIn(busHighByteIn), .busActive(busActive),
    .slaveReadN(slaveReadN), .slaveWriteN(slaveWriteN), .slaveSelectN(slaveSelectN));
`default_nettype wire

// file: sim/port_pins_model.sv
// Purpose: external pins resolving port drive against outside drive
// Assumes: outside drivers always present, no pull resistors
// Notes: driven pins read back the port value
`timescale 1ns/1ps
`default_nettype none
module port_pins_model (
    // both parties
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] extDrive,
    // level seen on each pin
    output logic [7:0] pinIn
);
    // port wins where it drives, outside elsewhere
    assign pinIn = (pinOe & pinOut) | (~pinOe & extDrive);
endmodule
`default_nettype wire

// file: sim/test_port_e_bidirectional_io.sv
// Purpose: self-checking bench for the eight-pin port
// Assumes: seed 32, one-cycle read latency
// Notes: expectations worked out from register writes and outside drive
`timescale 1ns/1ps
`default_nettype none
module test_port_e_bidirectional_io;
    logic clk, rst, regWrite, regRead, compareOut, captureIn, busHighByteDrive, busActive;
    logic slaveReadN, slaveWriteN, slaveSelectN;
    logic [2:0] regAddr;
    logic [7:0] regWrData, regRdData, pinIn, pinOut, pinOe, busHighByteOut, busHighByteIn, extDrive;
    logic [7:0] d, lat, dir;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] rstVal [1:5] = '{port_e_pkg::RST_OUTPUT_LATCH, port_e_pkg::RST_PIN_DIRECTION,
        port_e_pkg::RST_MEMORY_CONTROL, port_e_pkg::RST_SLAVE_PORT_CONTROL, port_e_pkg::RST_DEVICE_CONFIG};
    port_e_bidirectional_io port_e_bidirectional_io_i (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .compareOut(compareOut), .captureIn(captureIn),
        .busHighByteOut(busHighByteOut), .busHighByteDrive(busHighByteDrive),
        .busHighByteIn(busHighByteIn), .busActive(busActive), .slaveReadN(slaveReadN),
        .slaveWriteN(slaveWriteN), .slaveSelectN(slaveSelectN));
    port_pins_model port_pins_model_i (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive), .pinIn(pinIn));
    // ****
    // clock, bus tasks and checks
    // ****
    always #2.5 clk = ~clk;
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk) begin regWrite <= 1'b1; regAddr <= a; regWrData <= v; end
        @(posedge clk) regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk) begin regRead <= 1'b1; regAddr <= a; end
        @(posedge clk) regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // level on each pin: driven value where output, outside drive where input
    function automatic logic [7:0] exp_levels(input logic [7:0] l, input logic [7:0] t, input logic [7:0] x);
        return (l & ~t) | (x & t);
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #60000;
        bad_count++;
        summarize();
    end
    // ****
    // main sequence
    // ****
    initial begin
        clk = 0; rst = 1; regAddr = '0; regWrData = '0; regWrite = 0; regRead = 0;
        compareOut = 0; busHighByteOut = '0; busHighByteDrive = 0; extDrive = '0;
        void'($urandom(32));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("oe_reset", pinOe, 8'h00);
        for (int a = 1; a <= 5; a++) begin
            rd(a[2:0], d);
            chk("reset_value", d, rstVal[a]);
        end
        wr(3'h6, 8'h5a);
        rd(3'h6, d);
        chk("unmapped", d, port_e_pkg::READ_UNMAPPED);
        // latch, direction and pin read, corners first
        for (int i = 0; i < 14; i++) begin
            lat = 8'($urandom);
            dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i < 10) ? 8'h01 << (i - 2) : 8'($urandom);
            @(posedge clk) extDrive <= 8'($urandom);
            wr(port_e_pkg::OFF_OUTPUT_LATCH, lat);
            wr(port_e_pkg::OFF_PIN_DIRECTION, dir);
            settle();
            chk("pin_oe", pinOe, ~dir);
            chk("pin_out", pinOut & ~dir, lat & ~dir);
            rd(port_e_pkg::OFF_PIN_LEVELS, d);
            chk("pin_levels", d, exp_levels(lat, dir, extDrive));
            rd(port_e_pkg::OFF_OUTPUT_LATCH, d);
            wr(port_e_pkg::OFF_OUTPUT_LATCH, d ^ 8'h0f);
            rd(port_e_pkg::OFF_OUTPUT_LATCH, d);
            chk("latch_rmw", d, lat ^ 8'h0f);
            lat = lat ^ 8'h0f;
        end
        // slave port takes pins 0..2 as inputs
        wr(port_e_pkg::OFF_PIN_DIRECTION, 8'h07);
        wr(port_e_pkg::OFF_SLAVE_PORT_CONTROL, 8'h10);
        settle();
        chk("slave_oe", pinOe, 8'hf8);
        chk("slave_ctl", {5'h00, slaveSelectN, slaveWriteN, slaveReadN}, {5'h00, extDrive[2:0]});
        wr(port_e_pkg::OFF_SLAVE_PORT_CONTROL, 8'h00);
        // second channel routed to the top pin
        wr(port_e_pkg::OFF_DEVICE_CONFIG, 8'h02);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) compareOut <= k[0];
            settle();
            chk("compare_pin", {pinOe[7], pinOut[7]}, {1'b1, k[0]});
        end
        dir = 8'h87;
        wr(port_e_pkg::OFF_PIN_DIRECTION, dir);
        settle();
        chk("capture", {7'h00, captureIn}, {7'h00, extDrive[7]});
        wr(port_e_pkg::OFF_DEVICE_CONFIG, 8'h03);
        settle();
        chk("capture_off", {7'h00, captureIn}, 8'h00);
        // external bus owns all pins
        wr(port_e_pkg::OFF_MEMORY_CONTROL, 8'h00);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) begin busHighByteOut <= 8'($urandom); busHighByteDrive <= k[0]; end
            settle();
            chk("bus_active", {7'h00, busActive}, 8'h01);
            chk("bus_oe", pinOe, {8{k[0]}});
            chk("bus_in", busHighByteIn, exp_levels(busHighByteOut, {8{~k[0]}}, extDrive));
        end
        wr(port_e_pkg::OFF_MEMORY_CONTROL, 8'h80);
        settle();
        chk("bus_off", {7'h00, busActive}, 8'h00);
        chk("bus_off_oe", pinOe, ~dir);
        summarize();
    end
endmodule
`default_nettype wire
